// file: rtl/ncr_nco_control.sv
// Overview of operation
// R1: Oscillators run only while run enable bit 0 is one.
// R2: Run enable zero holds all oscillator logic and accumulators in reset.
// R3: Software sets run enable only after configuration and datapath enable.
// R4: Writing one to sync bit while it reads zero fires sync event.
// R5: Sync bit reads back last written value, never self-clears.
// R6: Hold bit freezes active selections; staged writes do not pass.
// R7: Hold bit zero makes oscillators follow the stored selection values.
// R8: Software sets hold before changing selections while oscillators run.
// R9: Phase-continuous operation only from hopping table entry zero.
// R10: Frequency change time is uncontrolled, so no phase coherence guarantee.
// R11: Transmit gate edges ramp each source amplitude linearly over set cycles.
// R12: Ramp code 0 means none; codes 1-7 give 16 to 1024 cycles.
// R13: Change ramp length and configuration only while transmit gate is low.
// R14: Summed mode with differing channel gates gives undefined ramp.
// R15: Sync source: 0 immediate, 1 next sysref rise, 2 next trigger with bank.
// R16: Summed mode adds both oscillators into one output for both channels.
// R17: Sync bit rising edge becomes one clean pulse toward the oscillators.
`timescale 1ns/1ps
module ncr_nco_control (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ncr_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic      [31:0]                   prdata,
  output logic                               pslverr,
  input  wire logic                          sampleTick,
  input  wire logic [4:0]                    stagedSelA,
  input  wire logic [4:0]                    stagedSelB,
  input  wire logic                          sysrefPin,
  input  wire logic                          trigPin,
  input  wire logic                          bankSelPin,
  input  wire logic                          transmitGateAPin,
  input  wire logic                          transmitGateBPin,
  output logic                               oscRun,
  output logic                               accReset,
  output logic      [4:0]                    activeSelA,
  output logic      [4:0]                    activeSelB,
  output logic                               phaseContA,
  output logic                               phaseContB,
  output logic                               summedMode,
  output logic                               ditherEn,
  output logic      [ncr_pkg::LEVEL_W-1:0]   rampLevelA,
  output logic      [ncr_pkg::LEVEL_W-1:0]   rampLevelB
);
  import ncr_pkg::*;

  typedef struct packed {
    logic [7:0]  runReg;
    logic [7:0]  syncReg;
    logic [7:0]  holdReg;
    logic [7:0]  rampReg;
    logic [7:0]  cfgReg;
    logic [7:0]  sctlReg;
    logic        syncArmed;
    logic [1:0]  armedSrc;
    logic        accReset;
    logic [4:0]  selA;
    logic [4:0]  selB;
    logic        phaseA;
    logic        phaseB;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [2:0]  sysSh;
    logic [2:0]  trigSh;
    logic [1:0]  bankSh;
    logic [1:0]  txASh;
    logic [1:0]  txBSh;
  } ncr_state_t;

  ncr_state_t state;
  ncr_state_t next_state;

  // Index decode; offsets are word aligned, so the word address is used
  function automatic logic [12:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = {1'b0, a[ADDR_W-1:2]};
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    logic [11:0] i;
    i = 12'(reg_index(a));
    reg_hit = (a[1:0] == 2'h0) &&
              (i == IDX_RUN_ENABLE || i == IDX_SW_SYNC || i == IDX_HOLD ||
               i == IDX_RAMP_LENGTH || i == IDX_OSC_CONFIG || i == IDX_SYNC_CTRL);
  endfunction

  logic                  running;
  logic                  gateA;
  logic                  gateB;
  logic [LEVEL_W-1:0]    levelA;
  logic [LEVEL_W-1:0]    levelB;

  assign running = state.runReg[0];
  // Either the pin or the register bit opens the gate
  assign gateA = state.txASh[1] | state.sctlReg[SCTL_TXREG_BIT];
  assign gateB = state.txBSh[1] | state.sctlReg[SCTL_TXREG_BIT];

  always_comb begin
    logic        setup;
    logic        accessDone;
    logic [11:0] idx;
    logic        sysRise;
    logic        trigRise;
    logic        syncFire;
    setup = psel && !penable;
    accessDone = psel && penable && state.pready;
    idx = 12'(reg_index(paddr));
    sysRise = state.sysSh[1] && !state.sysSh[2];
    trigRise = state.trigSh[1] && !state.trigSh[2];
    syncFire = 1'b0;
    next_state = state;

    // Pin synchronisers: stage 0 feeds only stage 1
    next_state.sysSh = {state.sysSh[1:0], sysrefPin};
    next_state.trigSh = {state.trigSh[1:0], trigPin};
    next_state.bankSh = {state.bankSh[0], bankSelPin};
    next_state.txASh = {state.txASh[0], transmitGateAPin};
    next_state.txBSh = {state.txBSh[0], transmitGateBPin};

    // One-cycle access phase: answer prepared during setup
    next_state.pready = setup;
    next_state.pslverr = setup && !reg_hit(paddr);
    if (setup) begin
      next_state.prdata = 32'h0000_0000;
      case (idx)
        IDX_RUN_ENABLE:  next_state.prdata[7:0] = state.runReg;
        IDX_SW_SYNC:     next_state.prdata[7:0] = state.syncReg; // R5
        IDX_HOLD:        next_state.prdata[7:0] = state.holdReg;
        IDX_RAMP_LENGTH: next_state.prdata[7:0] = state.rampReg;
        IDX_OSC_CONFIG:  next_state.prdata[7:0] = state.cfgReg;
        IDX_SYNC_CTRL:   next_state.prdata[7:0] = state.sctlReg;
        default:         next_state.prdata = 32'h0000_0000;
      endcase
    end

    if (accessDone && pwrite && reg_hit(paddr)) begin
      case (idx)
        IDX_RUN_ENABLE:  next_state.runReg = pwdata[7:0]; // R1
        IDX_SW_SYNC: begin
          next_state.syncReg = pwdata[7:0]; // R5
          syncFire = pwdata[0] && !state.syncReg[0]; // R4 R17
        end
        IDX_HOLD:        next_state.holdReg = pwdata[7:0];
        IDX_RAMP_LENGTH: next_state.rampReg = pwdata[7:0];
        IDX_OSC_CONFIG:  next_state.cfgReg = pwdata[7:0];
        IDX_SYNC_CTRL:   next_state.sctlReg = pwdata[7:0];
        default:         next_state.runReg = state.runReg;
      endcase
    end

    // Sync event by source; accReset is a single-cycle pulse
    next_state.accReset = 1'b0;
    if (state.syncArmed) begin
      case (ncr_sync_src_t'(state.armedSrc))
        SYNC_SYSREF: if (sysRise) begin
          next_state.accReset = 1'b1; // R15
          next_state.syncArmed = 1'b0;
        end
        SYNC_TRIG: if (trigRise && state.bankSh[1]) begin
          next_state.accReset = 1'b1; // R15
          next_state.syncArmed = 1'b0;
        end
        default: next_state.syncArmed = 1'b0;
      endcase
    end
    // A fresh trigger replaces any wait still pending
    if (syncFire) begin
      case (ncr_sync_src_t'(state.sctlReg[1:0]))
        SYNC_NOW: begin
          next_state.accReset = 1'b1; // R15
          next_state.syncArmed = 1'b0;
        end
        SYNC_SYSREF, SYNC_TRIG: begin
          next_state.syncArmed = 1'b1; // R15
          next_state.armedSrc = state.sctlReg[1:0];
        end
        default: next_state.syncArmed = 1'b0;
      endcase
    end
    if (!running) begin
      next_state.syncArmed = 1'b0; // R2
    end

    // Staged selections pass only while not held; timing is uncontrolled
    if (!state.holdReg[0]) begin
      next_state.selA = stagedSelA; // R7 R10
      next_state.selB = stagedSelB; // R7
    end // R6
    // Flag kept in a flop so the output needs no decode after the register
    next_state.phaseA = (next_state.selA[3:0] == 4'h0); // R9
    next_state.phaseB = (next_state.selB[3:0] == 4'h0); // R9
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= '{runReg: RST_RUN_ENABLE, syncReg: RST_SW_SYNC, holdReg: RST_HOLD,
                 rampReg: RST_RAMP_LENGTH, cfgReg: RST_OSC_CONFIG,
                 sctlReg: RST_SYNC_CTRL, phaseA: 1'b1, phaseB: 1'b1, default: '0};
    end else begin
      state <= next_state;
    end
  end

  // Two identical ramp units, one per channel gate
  ncr_ramp rampA (
    .mclk  (mclk),
    .rst   (rst),
    .clear (!running),
    .tick  (sampleTick),
    .gate  (gateA),
    .code  (state.rampReg[2:0]),
    .level (levelA)
  ); // R11 R12
  ncr_ramp rampB (
    .mclk  (mclk),
    .rst   (rst),
    .clear (!running),
    .tick  (sampleTick),
    .gate  (gateB),
    .code  (state.rampReg[2:0]),
    .level (levelB)
  ); // R11 R12

  assign pready     = state.pready;
  assign prdata     = state.prdata;
  assign pslverr    = state.pslverr;
  assign oscRun     = state.runReg[0]; // R1 R2
  assign accReset   = state.accReset;
  assign activeSelA = state.selA; // R6
  assign activeSelB = state.selB; // R6
  // Low four bits select the table entry; entry zero is phase-continuous
  assign phaseContA = state.phaseA; // R9
  assign phaseContB = state.phaseB; // R9
  assign summedMode = state.cfgReg[CFG_SUM_BIT]; // R16
  assign ditherEn   = state.cfgReg[CFG_DITHER_BIT];
  assign rampLevelA = levelA;
  assign rampLevelB = levelB;
endmodule

// file: rtl/ncr_pkg.sv
package ncr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_RUN_ENABLE  = 12'h308;
  localparam logic [11:0] IDX_SW_SYNC     = 12'h310;
  localparam logic [11:0] IDX_HOLD        = 12'h320;
  localparam logic [11:0] IDX_RAMP_LENGTH = 12'h330;
  localparam logic [11:0] IDX_OSC_CONFIG  = 12'h331;
  localparam logic [11:0] IDX_SYNC_CTRL   = 12'h340;

  localparam int          ADDR_W = 14;
  localparam logic [7:0]  RST_RUN_ENABLE  = 8'h00;
  localparam logic [7:0]  RST_SW_SYNC     = 8'h00;
  localparam logic [7:0]  RST_HOLD        = 8'h00;
  localparam logic [7:0]  RST_RAMP_LENGTH = 8'h00;
  localparam logic [7:0]  RST_OSC_CONFIG  = 8'h02;
  localparam logic [7:0]  RST_SYNC_CTRL   = 8'h00;

  // Field positions
  localparam int CFG_SUM_BIT    = 0;
  localparam int CFG_DITHER_BIT = 1;
  localparam int SCTL_TXREG_BIT = 2;

  // Full-scale ramp level and the step shift base
  localparam int          LEVEL_W    = 11;
  localparam logic [10:0] LEVEL_FULL = 11'h400;
  localparam logic [2:0]  STEP_BASE  = 3'h7;

  typedef enum logic [1:0] {
    SYNC_NOW    = 2'b00,
    SYNC_SYSREF = 2'b01,
    SYNC_TRIG   = 2'b10,
    SYNC_RSVD   = 2'b11
  } ncr_sync_src_t;

  // Level step per sample tick: 1024 / (16 << (code-1))
  function automatic logic [10:0] ramp_step(input logic [2:0] code);
    ramp_step = 11'h001 << (STEP_BASE - code);
  endfunction
endpackage

// file: rtl/ncr_ramp.sv
`timescale 1ns/1ps
module ncr_ramp (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         clear,
  input  wire logic                         tick,
  input  wire logic                         gate,
  input  wire logic [2:0]                   code,
  output logic      [ncr_pkg::LEVEL_W-1:0]  level
);
  import ncr_pkg::*;

  typedef struct packed {
    logic [LEVEL_W-1:0] level;
  } ncr_ramp_state_t;

  ncr_ramp_state_t state;
  ncr_ramp_state_t next_state;

  always_comb begin
    logic [LEVEL_W-1:0] target;
    logic [LEVEL_W-1:0] step;
    target = gate ? LEVEL_FULL : '0;
    step = ramp_step(code);
    next_state = state;
    if (clear) begin
      next_state.level = '0;
    end else if (tick && state.level != target) begin
      if (code == 3'h0) begin
        next_state.level = target; // R12
      end else if (gate) begin
        // Linear rise, clamped so a mid-ramp code change cannot overshoot
        next_state.level = (LEVEL_FULL - state.level < step) ? LEVEL_FULL
                                                             : state.level + step; // R11
      end else begin
        next_state.level = (state.level < step) ? '0 : state.level - step; // R11
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.level;
endmodule

// file: dv/ncr_nco_control_asserts.sv
`timescale 1ns/1ps
module ncr_nco_control_asserts (
  input wire logic                         mclk,
  input wire logic                         rst,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [ncr_pkg::ADDR_W-1:0]   paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pready,
  input wire logic                         sampleTick,
  input wire logic [4:0]                   stagedSelA,
  input wire logic                         oscRun,
  input wire logic                         accReset,
  input wire logic [4:0]                   activeSelA,
  input wire logic                         phaseContA,
  input wire logic [ncr_pkg::LEVEL_W-1:0]  rampLevelA
);
  import ncr_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic       wr;
  logic       holdBit;
  logic       syncBit;
  logic [1:0] src;
  assign wr = psel && penable && pready && pwrite;
  // Shadow copies of the bits that qualify the checks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      holdBit <= 1'b0;
      syncBit <= 1'b0;
      src     <= 2'b00;
    end else if (wr) begin
      if (paddr == {IDX_HOLD, 2'b00}) holdBit <= pwdata[0];
      if (paddr == {IDX_SW_SYNC, 2'b00}) syncBit <= pwdata[0];
      if (paddr == {IDX_SYNC_CTRL, 2'b00}) src <= pwdata[1:0];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("ready not a single cycle after setup");
  a_run_on: assert property (
    wr && paddr == {IDX_RUN_ENABLE, 2'b00} && pwdata[0] |-> ##[1:2] oscRun)
    else $error("run enable write not seen");
  a_off_silent: assert property (!oscRun [*2] |-> rampLevelA == '0)
    else $error("level nonzero while stopped");
  a_sync_now: assert property (
    wr && paddr == {IDX_SW_SYNC, 2'b00} && pwdata[0] && !syncBit && src == 2'b00 && oscRun
    |=> accReset)
    else $error("immediate sync missing");
  a_sync_single: assert property (accReset |=> !accReset)
    else $error("sync pulse too long");
  a_sel_frozen: assert property ($past(holdBit) |-> $stable(activeSelA))
    else $error("selection moved under hold");
  a_sel_follow: assert property (
    !$past(rst) && !$past(holdBit) |-> activeSelA == $past(stagedSelA))
    else $error("selection not followed");
  a_phase_entry: assert property (phaseContA == (activeSelA[3:0] == 4'h0))
    else $error("phase continuity flag wrong");
  a_ramp_tick: assert property (
    $past(oscRun) && !$past(sampleTick) |-> $stable(rampLevelA))
    else $error("level moved without tick");
  a_ramp_bound: assert property (rampLevelA <= LEVEL_FULL)
    else $error("level above full scale");
endmodule

bind ncr_nco_control ncr_nco_control_asserts u_chk (.mclk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .sampleTick, .stagedSelA, .oscRun, .accReset, .activeSelA,
  .phaseContA, .rampLevelA);

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ncr_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic        pready, pslverr, e, sampleTick = 1'b0, sysrefPin = 1'b0, trigPin = 1'b0;
  logic        bankSelPin = 1'b0, transmitGateAPin = 1'b0, transmitGateBPin = 1'b0;
  logic        oscRun, accReset, phaseContA, phaseContB, summedMode, ditherEn;
  logic [4:0]  stagedSelA = '0, stagedSelB = '0, activeSelA, activeSelB;
  logic [10:0] rampLevelA, rampLevelB;
  logic [11:0] ids[6] = '{IDX_RUN_ENABLE, IDX_SW_SYNC, IDX_HOLD, IDX_RAMP_LENGTH,
                          IDX_OSC_CONFIG, IDX_SYNC_CTRL};
  logic [4:0]  sels[3] = '{5'h10, 5'h00, 5'h0b};
  int          num_errors = 0, num_checks = 0, pulses = 0, model[int];

  ncr_nco_control dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .sampleTick, .stagedSelA, .stagedSelB, .sysrefPin, .trigPin,
    .bankSelPin, .transmitGateAPin, .transmitGateBPin, .oscRun, .accReset, .activeSelA,
    .activeSelB, .phaseContA, .phaseContB, .summedMode, .ditherEn, .rampLevelA, .rampLevelB);

  always #20 mclk = ~mclk;
  always @(posedge mclk) if (accReset === 1'b1) pulses++;

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Master holds the request until pready is sampled; bound guards a dead slave
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      num_errors++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, {idx, 2'b00}, {24'($urandom), d});
    model[idx] = d;
  endtask

  task automatic rdc(input logic [11:0] idx);
    apb(1'b0, {idx, 2'b00}, 32'h0);
    check(q, model.exists(idx) ? 32'(model[idx]) : 32'h0);
    check(32'(e), 32'(!model.exists(idx)));
  endtask

  // Counts level moves until the target is reached; tick runs every cycle here
  task automatic steps(input int n, input logic [10:0] t);
    int k;
    int m;
    logic [10:0] p;
    k = 0;
    m = 0;
    p = rampLevelA;
    while (rampLevelA !== t && m < 2000) begin
      @(posedge mclk);
      m++;
      if (rampLevelA !== p) k++;
      p = rampLevelA;
    end
    if (m == 2000) begin
      num_errors++;
      conclude();
    end
    check(k, n);
    check(rampLevelB, t);
  endtask

  initial begin
    void'($urandom(32'h4fb0));
    foreach (ids[i]) model[ids[i]] = 0;
    model[IDX_OSC_CONFIG] = 8'h02;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    foreach (ids[i]) rdc(ids[i]);
    rdc(12'h309);
    apb(1'b0, 14'h0c21, 32'h0);
    check(32'(e), 32'h1);
    foreach (ids[i]) wr(ids[i], 8'($urandom));
    foreach (ids[i]) rdc(ids[i]);
    check(32'(summedMode), 32'(model[IDX_OSC_CONFIG] & 1));
    check(32'(ditherEn), 32'((model[IDX_OSC_CONFIG] >> 1) & 1));
    $display("register test done");
    wr(IDX_RUN_ENABLE, 8'h01);
    @(posedge mclk);
    check(32'(oscRun), 32'h1);
    bankSelPin <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(IDX_SYNC_CTRL, 8'(s));
      wr(IDX_SW_SYNC, 8'h00);
      pulses = 0;
      wr(IDX_SW_SYNC, 8'h01);
      wr(IDX_SW_SYNC, 8'h01);
      sysrefPin <= 1'b1;
      trigPin   <= 1'b1;
      repeat (6) @(posedge mclk);
      sysrefPin <= 1'b0;
      trigPin   <= 1'b0;
      repeat (6) @(posedge mclk);
      check(pulses, 32'(s < 3));
    end
    $display("sync test done");
    foreach (sels[i]) begin
      wr(IDX_HOLD, 8'h00);
      stagedSelA <= sels[i];
      stagedSelB <= 5'($urandom);
      repeat (2) @(posedge mclk);
      check(activeSelA, sels[i]);
      check(activeSelB, stagedSelB);
      check(32'(phaseContA), 32'(sels[i][3:0] == 4'h0));
      check(32'(phaseContB), 32'(stagedSelB[3:0] == 4'h0));
      wr(IDX_HOLD, 8'h01);
      stagedSelA <= 5'($urandom);
      repeat (3) @(posedge mclk);
      check(activeSelA, sels[i]);
    end
    $display("hold test done");
    sampleTick <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(IDX_RAMP_LENGTH, 8'(c));
      if (c % 2) wr(IDX_SYNC_CTRL, 8'h04);
      else transmitGateAPin <= 1'b1;
      transmitGateBPin <= transmitGateAPin | ~c[0];
      steps(c == 0 ? 1 : 16 << (c - 1), 11'h400);
      wr(IDX_SYNC_CTRL, 8'h00);
      transmitGateAPin <= 1'b0;
      transmitGateBPin <= 1'b0;
      steps(c == 0 ? 1 : 16 << (c - 1), 11'h000);
    end
    $display("ramp test done");
    wr(IDX_RAMP_LENGTH, 8'h00);
    transmitGateAPin <= 1'b1;
    transmitGateBPin <= 1'b1;
    repeat (8) @(posedge mclk);
    wr(IDX_RUN_ENABLE, 8'h00);
    repeat (3) @(posedge mclk);
    check(rampLevelA, 11'h000);
    check(32'(oscRun), 32'h0);
    $display("stop test done");
    conclude();
  end
endmodule
